// ---- rcs_debug_host.sv ----
// background debug host model driving the debug access port
module rcs_debug_host
(
    input  wire logic             sys_clk,
    output rcs_pkg::rcs_bus_req_s bdm_req
);
    timeunit 1ns;
    timeprecision 1ns;

    initial bdm_req = '0;

    // one background command, strobe held for a single edge
    task automatic cmd(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bdm_req <= '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(posedge sys_clk);
        // released port shows no stale address or data
        bdm_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

// ---- rcs_pkg.sv ----
// constants and types shared by the reset cause and debug reset block
package rcs_pkg;

    localparam logic [15:0] STATUS_ADDR   = 16'h1800;
    localparam logic [15:0] FORCE_ADDR    = 16'h1801;
    localparam int          FORCE_BIT     = 0;

    localparam logic [15:0] ILL1_LO       = 16'h0470;
    localparam logic [15:0] ILL1_HI       = 16'h17FF;
    localparam logic [15:0] ILL2_LO       = 16'h1860;
    localparam logic [15:0] ILL2_HI       = 16'hBFFF;

    localparam logic [7:0]  POR_VALUE     = 8'h82;
    localparam logic [7:0]  READ_ZERO     = 8'h00;

    localparam int          CLK_NS        = 10;
    localparam int          RESET_HOLD_NS = 100;
    localparam int          RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0]  HOLD_LOAD     = 4'(RESET_HOLD_CYC - 1);
    localparam int          WDOG_TIMEOUT_CYC = 8192;

    typedef enum logic [1:0]
    {
        RCS_RUN  = 2'b00,
        RCS_HOLD = 2'b01
    } rcs_state_e;

    typedef struct packed
    {
        logic power_on_flag;
        logic ext_pin_flag;
        logic watchdog_reset_flag;
        logic illegal_opcode_flag;
        logic illegal_address_flag;
        logic clock_generator_fault_flag;
        logic low_voltage_flag;
        logic unused;
    } rcs_cause_s;

    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } rcs_bus_req_s;

endpackage

// ---- rcs_reset_cause.sv ----
// reset cause capture, watchdog restart and debug forced reset
// Summary of operation
// - the status register holds seven read-only cause flags in bits 7 to 1 and bit 0 reads zero.
// - a reset forced by the debug host with no other source active leaves every cause flag cleared.
// - any write to the status address restarts the watchdog and leaves the flags unchanged.
// - power-on sets the power-on and low-voltage flags and clears all others.
// - a low-voltage reset keeps the power-on flag, sets low-voltage and clears the rest.
// - any other reset clears power-on and low-voltage and sets each flag whose source was active.
// - a low level held on the reset pin causes a reset with the pin flag set.
// - a watchdog timeout resets with the watchdog flag set, never while the watchdog is disabled.
// - an unimplemented opcode, or stop or background entry while disabled, resets as illegal opcode.
// - an access between the end of RAM and the high-page registers resets as illegal address.
// - an access between the high-page registers and flash resets as illegal address.
// - accesses inside register areas never count as illegal addresses.
// - a low-voltage trip with reset and stop enables both set resets with the low-voltage flag.
// - only a background debug write may set the force reset bit; user writes are ignored.
// - every read of the force reset register returns zero.
// - a background write of one to bit 0 of the force register forces a full reset at once.
module rcs_reset_cause
#(
    parameter int WDOG_TIMEOUT = rcs_pkg::WDOG_TIMEOUT_CYC
)
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    input  wire logic                 reset_pin_b,
    input  wire logic                 lv_trip,
    input  wire logic                 clock_fault,
    input  wire rcs_pkg::rcs_bus_req_s cpu_req,
    input  wire rcs_pkg::rcs_bus_req_s bdm_req,
    input  wire logic                 opcode_unimpl,
    input  wire logic                 stop_exec,
    input  wire logic                 enter_background_instruction_exec,
    input  wire logic                 stop_mode_enable,
    input  wire logic                 background_mode_enable,
    input  wire logic                 watchdog_enable,
    input  wire logic                 low_voltage_reset_enable,
    input  wire logic                 low_voltage_stop_enable,
    output logic                      mcu_reset,
    output logic [7:0]                cpu_rdata,
    output logic [7:0]                bdm_rdata,
    output rcs_pkg::rcs_cause_s       reset_cause
);

    localparam int               WD_W     = $clog2(WDOG_TIMEOUT + 1);
    localparam logic [WD_W-1:0]  WD_LIMIT = WD_W'(WDOG_TIMEOUT - 1);

    function automatic logic addr_illegal
    (
        input logic [15:0] a
    );
        addr_illegal = ((a >= rcs_pkg::ILL1_LO) && (a <= rcs_pkg::ILL1_HI))
                    || ((a >= rcs_pkg::ILL2_LO) && (a <= rcs_pkg::ILL2_HI));
    endfunction

    // pin and detector inputs come from outside the clock domain
    logic [1:0]                sync1_reg;
    logic [1:0]                sync2_reg;
    rcs_pkg::rcs_state_e       state_reg;
    rcs_pkg::rcs_state_e       state_next;
    logic [3:0]                hold_reg;
    logic [3:0]                hold_next;
    logic [WD_W-1:0]           wd_cnt_reg;
    logic [WD_W-1:0]           wd_cnt_next;
    rcs_pkg::rcs_cause_s       cause_reg;
    rcs_pkg::rcs_cause_s       cause_next;
    rcs_pkg::rcs_cause_s       cause_other;
    rcs_pkg::rcs_cause_s       cause_lv;
    logic                      mcu_reset_reg;
    logic [7:0]                cpu_rdata_reg;
    logic [7:0]                cpu_rdata_next;
    logic [7:0]                bdm_rdata_reg;
    logic [7:0]                bdm_rdata_next;

    wire pin_active = sync2_reg[0];
    wire lv_active  = sync2_reg[1];
    wire running    = (state_reg == rcs_pkg::RCS_RUN);
    wire cpu_acc    = cpu_req.wr | cpu_req.rd;

    wire cpu_status = (cpu_req.addr == rcs_pkg::STATUS_ADDR);
    wire bdm_status = (bdm_req.addr == rcs_pkg::STATUS_ADDR);
    wire cpu_force  = (cpu_req.addr == rcs_pkg::FORCE_ADDR);
    wire bdm_force  = (bdm_req.addr == rcs_pkg::FORCE_ADDR);

    wire status_wr  = (cpu_req.wr & cpu_status)
                    | (bdm_req.wr & bdm_status);

    wire illegal_address_flag_hit   = cpu_acc & addr_illegal(cpu_req.addr);

    wire illegal_opcode_flag_hit   = opcode_unimpl
                    | (stop_exec & ~stop_mode_enable)
                    | (enter_background_instruction_exec & ~background_mode_enable);

    wire wdog_hit   = watchdog_enable & (wd_cnt_reg >= WD_LIMIT);

    wire lv_hit     = lv_active
                    & low_voltage_reset_enable
                    & low_voltage_stop_enable;

    // only the background port can reach the force bit
    wire force_hit  = bdm_req.wr & bdm_force
                    & bdm_req.wdata[rcs_pkg::FORCE_BIT];

    wire other_hit  = pin_active | wdog_hit | illegal_opcode_flag_hit
                    | illegal_address_flag_hit | clock_fault;

    wire any_hit    = running & (lv_hit | other_hit | force_hit);

    assign cause_other = rcs_pkg::rcs_cause_s'({1'b0, pin_active, wdog_hit,
                         illegal_opcode_flag_hit, illegal_address_flag_hit, clock_fault, 2'h0});

    assign cause_lv = rcs_pkg::rcs_cause_s'({cause_reg.power_on_flag,
                      5'h00, 1'b1, 1'b0});

    // low voltage takes priority, a forced reset alone clears all
    assign cause_next = !any_hit   ? cause_reg
                      : lv_hit     ? cause_lv
                      : other_hit  ? cause_other
                      : rcs_pkg::rcs_cause_s'(8'h00);

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            rcs_pkg::RCS_RUN:
            begin
                if (any_hit)
                begin
                    state_next = rcs_pkg::RCS_HOLD;
                end
            end
            rcs_pkg::RCS_HOLD:
            begin
                if (hold_reg == 4'h0)
                begin
                    state_next = rcs_pkg::RCS_RUN;
                end
            end
            default:
            begin
                state_next = rcs_pkg::RCS_RUN;
            end
        endcase
    end

    assign hold_next = any_hit ? rcs_pkg::HOLD_LOAD
                     : (hold_reg != 4'h0) ? hold_reg - 4'h1
                     : hold_reg;

    assign wd_cnt_next = (!running || status_wr || !watchdog_enable)
                       ? '0 : wd_cnt_reg + 1'b1;

    // force register always reads back as zero
    assign cpu_rdata_next = (cpu_req.rd && cpu_status) ? cause_reg
                          : rcs_pkg::READ_ZERO;

    assign bdm_rdata_next = (bdm_req.rd && bdm_status) ? cause_reg
                          : rcs_pkg::READ_ZERO;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
        end
        else
        begin
            sync1_reg <= {lv_trip, ~reset_pin_b};
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= rcs_pkg::RCS_RUN;
            hold_reg  <= 4'h0;
        end
        else
        begin
            state_reg <= state_next;
            hold_reg  <= hold_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cause_reg <= rcs_pkg::rcs_cause_s'(rcs_pkg::POR_VALUE);
        end
        else
        begin
            cause_reg <= cause_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wd_cnt_reg <= '0;
        end
        else
        begin
            wd_cnt_reg <= wd_cnt_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mcu_reset_reg <= 1'b0;
            cpu_rdata_reg <= 8'h00;
            bdm_rdata_reg <= 8'h00;
        end
        else
        begin
            mcu_reset_reg <= (state_next == rcs_pkg::RCS_HOLD);
            cpu_rdata_reg <= cpu_rdata_next;
            bdm_rdata_reg <= bdm_rdata_next;
        end
    end

    assign mcu_reset   = mcu_reset_reg;
    assign cpu_rdata   = cpu_rdata_reg;
    assign bdm_rdata   = bdm_rdata_reg;
    assign reset_cause = cause_reg;

    default clocking cb @(posedge sys_clk);
    endclocking

    default disable iff (!rst_b);

    status_read_a:
    assert property (cpu_req.rd && cpu_status
                     |=> (cpu_rdata == $past(cause_reg)) && !cpu_rdata[0])
    else $error("status read returned wrong value");

    force_clear_a:
    assert property (running && force_hit && !lv_hit && !other_hit
                     |=> (cause_reg == 8'h00) && mcu_reset)
    else $error("forced reset left a cause flag set");

    status_wr_keep_a:
    assert property (running && status_wr && !any_hit
                     |=> (cause_reg == $past(cause_reg)) && (wd_cnt_reg == '0))
    else $error("status write changed flags or kept watchdog count");

    lv_keep_por_a:
    assert property (running && lv_hit
                     |=> cause_reg.low_voltage_flag
                         && (cause_reg.power_on_flag == $past(cause_reg.power_on_flag))
                         && (cause_reg[6:2] == 5'h00))
    else $error("low voltage reset flags wrong");

    other_flags_a:
    assert property (running && other_hit && !lv_hit
                     |=> !cause_reg.power_on_flag && !cause_reg.low_voltage_flag
                         && (cause_reg.ext_pin_flag == $past(pin_active))
                         && (cause_reg.clock_generator_fault_flag == $past(clock_fault)))
    else $error("other reset flags wrong");

    pin_reset_a:
    assert property (running && pin_active && !lv_hit
                     |=> mcu_reset && cause_reg.ext_pin_flag)
    else $error("pin reset did not set the pin flag");

    wdog_block_a:
    assert property (!watchdog_enable |=> (wd_cnt_reg == '0) && !wdog_hit)
    else $error("watchdog ran while disabled");

    stop_illegal_a:
    assert property (running && stop_exec && !stop_mode_enable && !lv_hit
                     |=> mcu_reset && cause_reg.illegal_opcode_flag)
    else $error("disabled stop did not reset as illegal opcode");

    ill_range_a:
    assert property (running && cpu_acc && addr_illegal(cpu_req.addr) && !lv_hit
                     |=> mcu_reset && cause_reg.illegal_address_flag)
    else $error("illegal address did not reset");

    reg_area_a:
    assert property (cpu_acc && (cpu_status || cpu_force) |-> !illegal_address_flag_hit)
    else $error("register area access flagged illegal");

    user_force_a:
    assert property (running && cpu_req.wr && cpu_force && cpu_req.wdata[0]
                     && !force_hit && !lv_hit && !other_hit
                     |=> !mcu_reset)
    else $error("user write forced a reset");

    force_read_a:
    assert property (bdm_req.rd && bdm_force |=> bdm_rdata == 8'h00)
    else $error("force register read not zero");

    hold_len_a:
    assert property ($rose(mcu_reset) |-> mcu_reset [*8])
    else $error("reset pulse too short");

    lv_trip_a:
    assert property (running && lv_hit |=> mcu_reset ##0 (hold_reg == rcs_pkg::HOLD_LOAD))
    else $error("low voltage trip did not reset");

    wdog_flag_a:
    assert property (running && wdog_hit && !lv_hit
                     |=> mcu_reset && cause_reg.watchdog_reset_flag)
    else $error("watchdog timeout did not set its flag");

    enter_background_instruction_illegal_a:
    assert property (running && enter_background_instruction_exec && !background_mode_enable && !lv_hit
                     |=> mcu_reset && cause_reg.illegal_opcode_flag)
    else $error("disabled background entry did not reset");

    clk_fault_a:
    assert property (running && clock_fault && !lv_hit
                     |=> mcu_reset && cause_reg.clock_generator_fault_flag)
    else $error("clock fault did not set its flag");

    hold_keep_a:
    assert property (!running |=> cause_reg == $past(cause_reg))
    else $error("flags changed during reset hold");

    hold_end_a:
    assert property ($rose(mcu_reset)
                     |-> ##9 (mcu_reset && (hold_reg == 4'h0)) ##1 !mcu_reset)
    else $error("reset pulse length wrong");

    force_cov_c:
    cover property (running && force_hit ##1 mcu_reset);

    wdog_cov_c:
    cover property (running && wdog_hit ##1 cause_reg.watchdog_reset_flag);

    lv_cov_c:
    cover property (running && lv_hit ##1 cause_reg.low_voltage_flag);

    stat_wr_cov_c:
    cover property (running && status_wr && (wd_cnt_reg != '0));

    pin_cov_c:
    cover property (running && pin_active ##1 cause_reg.ext_pin_flag);

endmodule

// ---- rcs_reset_cause_test.sv ----
// self-checking bench for the reset cause block
module rcs_reset_cause_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic                  sys_clk, rst_b, reset_pin_b, lv_trip, clock_fault;
    logic                  opcode_unimpl, stop_exec, enter_background_instruction_exec, mcu_reset;
    logic                  stop_mode_enable, background_mode_enable, watchdog_enable;
    logic                  low_voltage_reset_enable, low_voltage_stop_enable;
    logic [4:0]            ev;
    logic [7:0]            cpu_rdata, bdm_rdata;
    rcs_pkg::rcs_bus_req_s cpu_req, bdm_req;
    rcs_pkg::rcs_cause_s   reset_cause;
    logic [15:0]           bad_addr [4] = '{16'h0470, 16'h17FF, 16'h1860, 16'hBFFF};
    int                    error_cnt = 0;
    int                    total_checks = 0;

    assign {lv_trip, clock_fault, enter_background_instruction_exec, stop_exec, opcode_unimpl} = ev;

    rcs_reset_cause #(.WDOG_TIMEOUT(16)) u_rcs_reset_cause
    (
        .sys_clk, .rst_b, .reset_pin_b, .lv_trip, .clock_fault, .cpu_req, .bdm_req,
        .opcode_unimpl, .stop_exec, .enter_background_instruction_exec, .stop_mode_enable,
        .background_mode_enable, .watchdog_enable, .low_voltage_reset_enable,
        .low_voltage_stop_enable, .mcu_reset, .cpu_rdata, .bdm_rdata, .reset_cause
    );

    rcs_debug_host u_host
    (
        .sys_clk,
        .bdm_req
    );

    task automatic results;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        if (seen !== exp)
            error_cnt++;
    endtask

    task automatic cpu(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cpu_req <= '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(posedge sys_clk);
        cpu_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        #1;
    endtask

    task automatic pulse(input logic [4:0] m);
        @(posedge sys_clk);
        ev <= m;
        @(posedge sys_clk);
        ev <= 5'h00;
        #1;
    endtask

    task automatic quiet(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            #1;
            check(8'(mcu_reset), 8'h00);
        end
    endtask

    // wait for a reset, compare its flags and its length
    task automatic expect_reset(input logic [7:0] exp);
        int n;
        #1;
        n = 0;
        while (mcu_reset !== 1'b1 && n < 20)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(reset_cause, exp);
        n = 0;
        while (mcu_reset === 1'b1 && n < 30)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(8'(n), 8'(rcs_pkg::RESET_HOLD_CYC));
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (3000) @(posedge sys_clk);
        error_cnt++;
        results();
    end

    initial
    begin
        rst_b = 1'b0;
        reset_pin_b = 1'b1;
        ev = 5'h00;
        cpu_req = '0;
        {stop_mode_enable, background_mode_enable, watchdog_enable} = 3'b000;
        {low_voltage_reset_enable, low_voltage_stop_enable} = 2'b00;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1;
        check(reset_cause, rcs_pkg::POR_VALUE);
        cpu(1'b0, rcs_pkg::STATUS_ADDR, 8'h00);
        check(cpu_rdata, 8'h82);
        low_voltage_reset_enable <= 1'b1;
        pulse(5'h10);
        quiet(12);
        low_voltage_stop_enable <= 1'b1;
        pulse(5'h10);
        expect_reset(8'h82);
        pulse(5'h01);
        expect_reset(8'h10);
        pulse(5'h02);
        expect_reset(8'h10);
        pulse(5'h04);
        expect_reset(8'h10);
        stop_mode_enable <= 1'b1;
        background_mode_enable <= 1'b1;
        pulse(5'h06);
        quiet(12);
        pulse(5'h08);
        expect_reset(8'h04);
        pulse(5'h10);
        expect_reset(8'h02);
        foreach (bad_addr[i])
        begin
            cpu(1'b0, bad_addr[i], 8'h00);
            expect_reset(8'h08);
        end
        cpu(1'b1, 16'h1802, 8'hFF);
        cpu(1'b0, 16'h185F, 8'h00);
        quiet(12);
        @(posedge sys_clk);
        reset_pin_b <= 1'b0;
        repeat (3) @(posedge sys_clk);
        reset_pin_b <= 1'b1;
        expect_reset(8'h40);
        watchdog_enable <= 1'b1;
        repeat (4)
        begin
            cpu(1'b1, rcs_pkg::STATUS_ADDR, 8'hFF);
            quiet(8);
        end
        cpu(1'b0, rcs_pkg::STATUS_ADDR, 8'h00);
        check(cpu_rdata, 8'h40);
        expect_reset(8'h20);
        @(posedge sys_clk);
        watchdog_enable <= 1'b0;
        quiet(40);
        u_host.cmd(1'b0, rcs_pkg::STATUS_ADDR, 8'h00);
        #1;
        check(bdm_rdata, 8'h20);
        cpu(1'b1, rcs_pkg::FORCE_ADDR, 8'h01);
        quiet(12);
        u_host.cmd(1'b1, rcs_pkg::FORCE_ADDR, 8'h00);
        quiet(12);
        u_host.cmd(1'b0, rcs_pkg::FORCE_ADDR, 8'h00);
        #1;
        check(bdm_rdata, rcs_pkg::READ_ZERO);
        cpu(1'b0, rcs_pkg::FORCE_ADDR, 8'h00);
        check(cpu_rdata, rcs_pkg::READ_ZERO);
        u_host.cmd(1'b1, rcs_pkg::FORCE_ADDR, 8'h01);
        #1;
        expect_reset(8'h00);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1;
        check(reset_cause, rcs_pkg::POR_VALUE);
        results();
    end
endmodule
